/* File: core/pfm_pkg.sv */
// Package: constants and carrier types for the port function mux
package pfm_pkg;
	// Bus configuration bit positions
	localparam int BCR_EXT_ADDR_BIT = 0;
	localparam int BCR_EMULATION_BIT = 3;
	localparam int BCR_IRQ_PIN_SEL_BIT = 6;
	localparam int BCR_EXT_MEMORY_BIT = 7;
	// Reset values of the configuration
	localparam logic [7:0] BCR_RST_NORMAL = 8'h00;
	localparam logic [7:0] BCR_RST_EMULATION = 8'h89;
	localparam logic [7:0] PORT3_SELECT_ENABLES_RST = 8'h00;
	// Selects 3..7 are gated by the phase-high half
	localparam logic [7:0] CS_CLOCKED_MASK = 8'hf8;
	// Edge pins: low 7 rise-sensitive, high 5 fall-sensitive
	localparam int EDGE_N = 12;
	localparam logic [11:0] EDGE_RISE_MASK = 12'h07f;
	// Port pin positions of the special functions
	localparam int P4_NMI_BIT = 0;
	localparam int P4_LVL1_BIT = 1;
	localparam int P4_LVL2_BIT = 2;
	localparam int P6_RX_BIT = 0;
	localparam int P6_TX_BIT = 1;
	// Async control bit positions
	localparam int ASYNC_CTRL_STATUS_TX_EN_BIT = 0;
	localparam int ASYNC_CTRL_STATUS_RX_EN_BIT = 5;
	// Synchroniser width and reset image (bus enable idles high)
	localparam int SYNC_W = 28;
	localparam logic [27:0] SYNC_RST = 28'h800_0000;
	// Cycles after reset release before the bus enable strap is read
	localparam logic [1:0] STRAP_WAIT = 2'h2;
	localparam logic [7:0] ALL_ONES8 = 8'hff;
	localparam logic [15:0] ALL_ONES16 = 16'hffff;

	// One 8-bit port: output values and output enables
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} pfm_port_s;

	// Processor bus cycle as seen by the mux
	typedef struct packed {
		logic        access;
		logic        onchip;
		logic        we;
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic [7:0]  rdata;
	} pfm_cpu_s;
endpackage

/* File: core/pfm_pin_mux.sv */
// Module: port function mux, chip selects and pin interrupt inputs
module pfm_pin_mux (
	// Clock and reset
	input  wire logic              sys_clk_i,
	input  wire logic              rstn_i,
	// Phase and processor state
	input  wire logic              phase_high_i,
	input  wire logic              cpu_irq_disable_i,
	input  wire pfm_pkg::pfm_cpu_s cpu_i,
	// Configuration writes
	input  wire logic              bcr_we_i,
	input  wire logic [7:0]        bcr_wdata_i,
	input  wire logic              port3_select_enables_we_i,
	input  wire logic [7:0]        port3_select_enables_wdata_i,
	input  wire logic [7:0]        async_ctrl_i,
	input  wire logic              uart_uses_timer_i,
	// Interrupt enables and clears
	input  wire logic [11:0]       edge_sel_i,
	input  wire logic [11:0]       edge_en_i,
	input  wire logic [11:0]       edge_clr_i,
	input  wire logic [1:0]        level_en_i,
	// Timer A
	input  wire logic              timer_a_timeout_i,
	// General port data
	input  wire pfm_pkg::pfm_port_s gpio0_i,
	input  wire pfm_pkg::pfm_port_s gpio1_i,
	input  wire pfm_pkg::pfm_port_s gpio2_i,
	input  wire pfm_pkg::pfm_port_s gpio6_i,
	input  wire logic [7:0]        p3_data_i,
	input  wire logic              uart_tx_i,
	// Pins in
	input  wire logic              bus_enable_in_i,
	input  wire logic              timer_a_pulse_in_i,
	input  wire logic [7:0]        p2_in_i,
	input  wire logic [7:0]        p4_in_i,
	input  wire logic [7:0]        p5_in_i,
	input  wire logic [1:0]        p6_in_i,
	// Pins out
	output pfm_pkg::pfm_port_s     p0_o,
	output pfm_pkg::pfm_port_s     p1_o,
	output pfm_pkg::pfm_port_s     p2_o,
	output pfm_pkg::pfm_port_s     p6_o,
	output logic [7:0]             p3_o,
	output logic                   timer_a_wave_out_o,
	// Status to core
	output logic [7:0]             bus_config_o,
	output logic [7:0]             port3_select_o,
	output logic [11:0]            edge_flags_o,
	output logic [1:0]             second_flag_o,
	output logic                   irq_o,
	output logic                   nmi_o,
	output logic                   uart_rx_o,
	output logic                   timer_a_count_o,
	output logic [7:0]             ext_rdata_o
);
	// Block of external memory hit by an address, one-hot
	// Eight equal blocks; the split is a choice of this block
	function automatic logic [7:0] cs_hit(input logic [15:0] a);
		cs_hit = 8'h01 << a[15:13];
	endfunction

	// Synchroniser stages; stage one is read only by stage two
	// Reset image holds bus enable high, so no false emulation strap
	logic [27:0] sync1_q, sync2_q;
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sync1_q <= pfm_pkg::SYNC_RST;
			sync2_q <= pfm_pkg::SYNC_RST;
		end else begin
			sync1_q <= {bus_enable_in_i, timer_a_pulse_in_i, p6_in_i,
				p5_in_i, p4_in_i, p2_in_i};
			sync2_q <= sync1_q;
		end
	end

	// Synchronised pin views
	logic       be_s, tin_s;
	logic [1:0] p6_s;
	logic [7:0] p5_s, p4_s, p2_s;
	assign {be_s, tin_s, p6_s, p5_s, p4_s, p2_s} = sync2_q;

	// Configuration state
	logic [7:0] bcr_q, bcr_d, port3_select_enables_q, port3_select_enables_d;
	logic [1:0] strap_cnt_q, strap_cnt_d;
	logic       strap_done_q, strap_done_d;

	// Strap catch after release, then software writes
	always_comb begin
		bcr_d = bcr_q;
		port3_select_enables_d = port3_select_enables_q;
		strap_cnt_d = strap_cnt_q;
		strap_done_d = strap_done_q;
		if (!strap_done_q) begin
			// Wait for the bus enable pin to pass the synchroniser
			if (strap_cnt_q == pfm_pkg::STRAP_WAIT) begin
				strap_done_d = 1'b1;
				bcr_d = be_s ? pfm_pkg::BCR_RST_NORMAL
					: pfm_pkg::BCR_RST_EMULATION;
			end else begin
				strap_cnt_d = strap_cnt_q + 2'h1;
			end
		end else begin
			// Software writes only count once the strap has been taken
			if (bcr_we_i) begin
				bcr_d = bcr_wdata_i;
			end
			if (port3_select_enables_we_i) begin
				port3_select_enables_d = port3_select_enables_wdata_i;
			end
		end
	end

	// Configuration registers
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bcr_q <= pfm_pkg::BCR_RST_NORMAL;
			port3_select_enables_q <= pfm_pkg::PORT3_SELECT_ENABLES_RST;
			strap_cnt_q <= 2'h0;
			strap_done_q <= 1'b0;
		end else begin
			bcr_q <= bcr_d;
			port3_select_enables_q <= port3_select_enables_d;
			strap_cnt_q <= strap_cnt_d;
			strap_done_q <= strap_done_d;
		end
	end

	// Decoded configuration
	logic ext_mode, emu_mode, irq_pin_sel, ext_mem;
	logic [7:0] cs_en;
	assign ext_mem = bcr_q[pfm_pkg::BCR_EXT_MEMORY_BIT];
	assign ext_mode = bcr_q[pfm_pkg::BCR_EXT_ADDR_BIT] & ext_mem;
	assign emu_mode = bcr_q[pfm_pkg::BCR_EMULATION_BIT];
	assign irq_pin_sel = bcr_q[pfm_pkg::BCR_IRQ_PIN_SEL_BIT];
	// Top select enabled by the memory bit too, so the emulation strap turns it on
	assign cs_en = port3_select_enables_q | {ext_mem, 7'h00};

	// Interrupt state
	logic [11:0] edge_prev_q, edge_prev_d, edge_flag_q, edge_flag_d;
	logic [11:0] edge_cur, edge_hit;
	logic [1:0]  lvl_q, lvl_d;
	logic        nmi_prev_q, nmi_prev_d, nmi_q, nmi_d;
	logic        irq_q, irq_d;

	// Edge pins gathered: rising ones low, falling ones high
	assign edge_cur = {p5_s[7], p5_s[3], p5_s[2], p4_s[7], p4_s[6],
		p5_s[6], p5_s[5], p5_s[4], p5_s[1], p5_s[0], p4_s[5], p4_s[4]};
	// A change whose new level matches the pin's polarity
	assign edge_hit = (edge_cur ^ edge_prev_q)
		& ~(edge_cur ^ pfm_pkg::EDGE_RISE_MASK) & edge_sel_i;

	// Flags, level requests and the processor request lines
	always_comb begin
		edge_prev_d = edge_cur;
		// Set wins over a clear in the same cycle
		edge_flag_d = (edge_flag_q & ~edge_clr_i) | edge_hit;
		// Level flags follow the pin; nothing latches them
		lvl_d = irq_pin_sel ? ~{p4_s[pfm_pkg::P4_LVL2_BIT],
			p4_s[pfm_pkg::P4_LVL1_BIT]} : 2'h0;
		// Falling edge of the non-maskable pin gives a one-cycle pulse
		nmi_prev_d = p4_s[pfm_pkg::P4_NMI_BIT];
		nmi_d = irq_pin_sel & nmi_prev_q
			& ~p4_s[pfm_pkg::P4_NMI_BIT];
		// Maskable request: enabled edge and level flags together
		irq_d = ~cpu_irq_disable_i & (|(edge_flag_q & edge_en_i)
			| |(lvl_q & level_en_i));
	end

	// Interrupt registers
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			edge_prev_q <= 12'h000;
			edge_flag_q <= 12'h000;
			lvl_q <= 2'h0;
			nmi_prev_q <= 1'b0;
			nmi_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			edge_prev_q <= edge_prev_d;
			edge_flag_q <= edge_flag_d;
			lvl_q <= lvl_d;
			nmi_prev_q <= nmi_prev_d;
			nmi_q <= nmi_d;
			irq_q <= irq_d;
		end
	end

	// Pin output state
	pfm_pkg::pfm_port_s p0_q, p0_d, p1_q, p1_d, p2_q, p2_d, p6_q, p6_d;
	logic [7:0] p3_q, p3_d, rdata_q, rdata_d;
	logic       timer_a_wave_out_q, timer_a_wave_out_d, tin_prev_q, tin_prev_d, tcnt_q, tcnt_d;
	logic       rx_q, rx_d;
	logic [7:0] cs_act, cs_n;

	// Selects only for external cycles; clocked ones need phase high
	assign cs_act = cs_hit(cpu_i.addr) & {8{cpu_i.access & ~cpu_i.onchip}}
		& (~pfm_pkg::CS_CLOCKED_MASK | {8{phase_high_i}});

	// Select pins are active low
	assign cs_n = ~(cs_act & cs_en);

	// Bus, select, UART and timer pin muxing
	always_comb begin
		// Ports fall back to their ordinary drive
		p0_d = gpio0_i;
		p1_d = gpio1_i;
		p2_d = gpio2_i;
		if (ext_mode | emu_mode) begin
			// Address always shown; masked to ones on-chip unless tracing
			p0_d.out = (cpu_i.onchip & ~emu_mode) ? pfm_pkg::ALL_ONES8
				: cpu_i.addr[7:0];
			p1_d.out = (cpu_i.onchip & ~emu_mode) ? pfm_pkg::ALL_ONES8
				: cpu_i.addr[15:8];
			// Bus enable low turns the bus round for emulator access
			p0_d.oe = {8{be_s}};
			p1_d.oe = {8{be_s}};
			if (cpu_i.onchip) begin
				p2_d.out = emu_mode ? (cpu_i.we ? cpu_i.wdata : cpu_i.rdata)
					: pfm_pkg::ALL_ONES8;
			end else begin
				p2_d.out = cpu_i.wdata;
			end
			// Never driven in the low half, which leaves turnaround time
			p2_d.oe = {8{be_s & phase_high_i
				& (cpu_i.onchip | cpu_i.we)}};
		end
		// Port 3: select where enabled, else the data register
		p3_d = (cs_en & cs_n) | (~cs_en & p3_data_i);
		// Port 6 handed over to the UART pin by pin
		p6_d = gpio6_i;
		if (async_ctrl_i[pfm_pkg::ASYNC_CTRL_STATUS_RX_EN_BIT]) begin
			p6_d.oe[pfm_pkg::P6_RX_BIT] = 1'b0;
		end
		if (async_ctrl_i[pfm_pkg::ASYNC_CTRL_STATUS_TX_EN_BIT]) begin
			p6_d.out[pfm_pkg::P6_TX_BIT] = uart_tx_i;
			p6_d.oe[pfm_pkg::P6_TX_BIT] = 1'b1;
		end
		// Receive view idles high while the receiver is off
		rx_d = async_ctrl_i[pfm_pkg::ASYNC_CTRL_STATUS_RX_EN_BIT]
			? p6_s[pfm_pkg::P6_RX_BIT] : 1'b1;
		// Data bus read back through the synchroniser
		rdata_d = p2_s;
		// Pulse input counted only while the UART leaves timer A alone
		tin_prev_d = tin_s;
		tcnt_d = ~uart_uses_timer_i & tin_prev_q & ~tin_s;
		timer_a_wave_out_d = timer_a_wave_out_q ^ timer_a_timeout_i;
	end

	// Pin registers; select pins idle high
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			p0_q <= '0;
			p1_q <= '0;
			p2_q <= '0;
			p6_q <= '0;
			p3_q <= pfm_pkg::ALL_ONES8;
			rdata_q <= 8'h00;
			rx_q <= 1'b1;
			tin_prev_q <= 1'b0;
			tcnt_q <= 1'b0;
			timer_a_wave_out_q <= 1'b0;
		end else begin
			p0_q <= p0_d;
			p1_q <= p1_d;
			p2_q <= p2_d;
			p6_q <= p6_d;
			p3_q <= p3_d;
			rdata_q <= rdata_d;
			rx_q <= rx_d;
			tin_prev_q <= tin_prev_d;
			tcnt_q <= tcnt_d;
			timer_a_wave_out_q <= timer_a_wave_out_d;
		end
	end

	// Port pins straight from flip-flops
	assign p0_o = p0_q;
	assign p1_o = p1_q;
	assign p2_o = p2_q;
	assign p6_o = p6_q;
	assign p3_o = p3_q;
	assign timer_a_wave_out_o = timer_a_wave_out_q;

	// Configuration views; the enables already fold in the top block
	assign bus_config_o = bcr_q;
	assign port3_select_o = cs_en;

	// Interrupt flags and request lines
	assign edge_flags_o = edge_flag_q;
	assign second_flag_o = lvl_q;
	assign irq_o = irq_q;
	assign nmi_o = nmi_q;

	// Receive view, timer pulse and synced bus data
	assign uart_rx_o = rx_q;
	assign timer_a_count_o = tcnt_q;
	assign ext_rdata_o = rdata_q;
endmodule

/* File: testbench/pfm_ext_model.sv */
// Partner model: far side of the data bus and the timer pulse source
module pfm_ext_model (
	// Clock and device pins
	input  wire logic               sys_clk_i,
	input  wire pfm_pkg::pfm_port_s p2_i,
	input  wire logic               run_i,
	// Pin levels back to the device
	output logic [7:0]              p2_in_o,
	output logic                    pulse_o
);
	logic [7:0] last_q = 8'h00;
	logic [2:0] div_q = 3'h0;
	// Last driven byte and pulse divider
	always @(posedge sys_clk_i) begin
		if (p2_i.oe != 8'h00) begin
			last_q <= p2_i.out;
		end
		div_q <= div_q + 3'h1;
	end
	// Released bus shows the inverse, so a stale sample is caught
	assign p2_in_o = (p2_i.oe != 8'h00) ? p2_i.out : ~last_q;
	// Eight-cycle period keeps the pulse input well under half rate
	assign pulse_o = run_i ? div_q[2] : 1'h1;
endmodule

/* File: testbench/pfm_pin_mux_chk.sv */
// Checker: bus masking, chip selects and interrupt relations
module pfm_pin_mux_chk (
	// Clock, reset and core state
	input wire logic               sys_clk_i,
	input wire logic               rstn_i,
	input wire logic               phase_high_i,
	input wire logic               cpu_irq_disable_i,
	input wire pfm_pkg::pfm_cpu_s  cpu_i,
	input wire logic [11:0]        edge_en_i,
	// Design outputs
	input wire pfm_pkg::pfm_port_s p0_o,
	input wire pfm_pkg::pfm_port_s p1_o,
	input wire pfm_pkg::pfm_port_s p2_o,
	input wire logic [7:0]         p3_o,
	input wire logic [7:0]         bus_config_o,
	input wire logic [7:0]         port3_select_o,
	input wire logic [11:0]        edge_flags_o,
	input wire logic               irq_o,
	input wire logic               nmi_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);
	// Bus pins; outputs lag their cause by one edge
	a_addr_masked: assert property (
		(bus_config_o & 8'h89) == 8'h81 && cpu_i.access && cpu_i.onchip
		|=> {p1_o.out, p0_o.out} == 16'hffff) else $error("address not masked");
	a_data_off: assert property (
		!phase_high_i && (bus_config_o[3] || (bus_config_o & 8'h81) == 8'h81)
		|=> p2_o.oe == 8'h00) else $error("data driven in low half");
	// Chip selects
	a_cs_unclocked: assert property (
		cpu_i.access && !cpu_i.onchip && cpu_i.addr[15:13] == 3'h0 && port3_select_o[0]
		|=> !p3_o[0]) else $error("select 0 not active");
	a_cs_clocked: assert property (
		!phase_high_i && port3_select_o[3] |=> p3_o[3]) else $error("select 3 in low half");
	a_top_forced: assert property (
		bus_config_o[7] |-> port3_select_o[7]) else $error("top select not forced");
	// Interrupt outputs
	a_irq_edge: assert property (
		|(edge_flags_o & edge_en_i) && !cpu_irq_disable_i |=> irq_o)
		else $error("edge irq missing");
	a_irq_mask: assert property (
		cpu_irq_disable_i |=> !irq_o) else $error("irq not masked");
	a_nmi_pulse: assert property (
		nmi_o |=> !nmi_o) else $error("nmi pulse too long");
	c_nmi: cover property (nmi_o);
	c_irq: cover property (irq_o && edge_flags_o[7]);
	c_cs3: cover property (!p3_o[3]);
endmodule
bind pfm_pin_mux pfm_pin_mux_chk u_chk (.*);

/* File: testbench/pfm_pin_mux_tb.sv */
// Testbench: port function mux scenarios
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
$display("BAD t=%0t got %h exp %h", $time, a, e); end end
module pfm_pin_mux_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// Stimulus; gpio and tx data tied, the pin functions are the subject
	logic               sys_clk_i = 1'h0, rstn_i = 1'h0, phase_high_i = 1'h0, run = 1'h0;
	logic               cpu_irq_disable_i = 1'h0, bcr_we_i = 1'h0, port3_select_enables_we_i = 1'h0;
	logic               bus_enable_in_i = 1'h0, uart_uses_timer_i = 1'h0, uart_tx_i = 1'h0;
	logic               timer_a_timeout_i = 1'h0, w;
	logic [7:0]         bcr_wdata_i = 8'h00, port3_select_enables_wdata_i = 8'h00, async_ctrl_i = 8'h00;
	logic [7:0]         p3_data_i = 8'h5a, p4_in_i = 8'h47, p5_in_i = 8'h00;
	logic [11:0]        edge_sel_i = 12'h000, edge_en_i = 12'h000, edge_clr_i = 12'h000;
	logic [1:0]         level_en_i = 2'h0, p6_in_i = 2'h3;
	pfm_pkg::pfm_cpu_s  cpu_i = '0;
	pfm_pkg::pfm_port_s gpio0_i = '0, gpio1_i = '0, gpio2_i = '0, gpio6_i = 16'hff00;
	// Observed
	pfm_pkg::pfm_port_s p0_o, p1_o, p2_o, p6_o;
	logic [7:0]         p3_o, bus_config_o, port3_select_o, ext_rdata_o, p2_in_i;
	logic [11:0]        edge_flags_o;
	logic [1:0]         second_flag_o;
	logic               timer_a_wave_out_o, irq_o, nmi_o, uart_rx_o, timer_a_count_o;
	logic               timer_a_pulse_in_i;
	int                 num_errors = 0, checks_done = 0, cycles = 0, n;
	pfm_pin_mux uut (.*);
	pfm_ext_model u_far (.sys_clk_i, .p2_i(p2_o), .run_i(run), .p2_in_o(p2_in_i),
		.pulse_o(timer_a_pulse_in_i));
	initial forever #12.5 sys_clk_i = ~sys_clk_i;
	// Phase half-rate square wave and hang guard
	always @(posedge sys_clk_i) begin
		phase_high_i <= ~phase_high_i;
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			conclude();
		end
	end
	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk_i);
	endtask
	// Samples just after an edge read the settled values before it
	task automatic cfg(input logic [7:0] bus_config_reg, input logic [7:0] pcs);
		@(posedge sys_clk_i);
		bcr_wdata_i <= bus_config_reg;
		port3_select_enables_wdata_i <= pcs;
		bcr_we_i <= 1'h1;
		port3_select_enables_we_i <= 1'h1;
		@(posedge sys_clk_i);
		bcr_we_i <= 1'h0;
		port3_select_enables_we_i <= 1'h0;
		cyc(2);
	endtask
	task automatic rst(input logic be, input logic [7:0] exp);
		rstn_i <= 1'h0;
		bus_enable_in_i <= be;
		cyc(20);
		rstn_i <= 1'h1;
		cyc(5);
		`CHK(bus_config_o, exp)
		`CHK(port3_select_o, {exp[7], 7'h00})
		$display("reset strap done");
	endtask
	task automatic t_bus();
		cfg(8'h81, 8'h00);
		cpu_i <= {1'h1, 1'h1, 1'h0, 16'h1234, 8'ha5, 8'h3c};
		cyc(2);
		`CHK({p1_o.out, p0_o.out}, 16'hffff)
		n = 0;
		repeat (4) begin
			@(posedge sys_clk_i);
			n += (p2_o.oe === 8'hff && p2_o.out === 8'hff);
		end
		`CHK(n, 2)
		cpu_i.onchip <= 1'h0;
		cyc(2);
		`CHK({p1_o.out, p0_o.out}, 16'h1234)
		cfg(8'h89, 8'h00);
		cpu_i <= {1'h1, 1'h1, 1'h1, 16'h1234, 8'ha5, 8'h3c};
		cyc(2);
		`CHK({p1_o.out, p0_o.out}, 16'h1234)
		n = 0;
		repeat (4) begin
			@(posedge sys_clk_i);
			n += (p2_o.oe === 8'hff && p2_o.out === 8'ha5);
		end
		`CHK(n, 2)
		$display("bus test done");
	endtask
	task automatic t_cs();
		cfg(8'h00, 8'h09);
		cpu_i <= {1'h1, 1'h0, 1'h0, 16'h0100, 8'h00, 8'h00};
		cyc(2);
		n = 0;
		repeat (4) begin
			@(posedge sys_clk_i);
			n += (p3_o[1:0] === 2'h2);
		end
		`CHK(n, 4)
		cpu_i.addr <= 16'h6000;
		cyc(2);
		n = 0;
		repeat (4) begin
			@(posedge sys_clk_i);
			n += (p3_o[3] === 1'h0);
		end
		`CHK(n, 2)
		`CHK(ext_rdata_o, 8'h5a)
		cpu_i <= '0;
		$display("select test done");
	endtask
	task automatic t_edge();
		edge_sel_i <= 12'hfff;
		edge_en_i <= 12'h084;
		p5_in_i <= 8'h01;
		cyc(6);
		`CHK(edge_flags_o, 12'h004)
		`CHK(irq_o, 1'h1)
		cpu_irq_disable_i <= 1'h1;
		edge_clr_i <= 12'h004;
		@(posedge sys_clk_i);
		edge_clr_i <= 12'h000;
		p5_in_i <= 8'h00;
		p4_in_i <= 8'h07;
		cyc(6);
		`CHK(edge_flags_o, 12'h080)
		`CHK(irq_o, 1'h0)
		p4_in_i <= 8'h47;
		cyc(6);
		`CHK(edge_flags_o, 12'h080)
		cpu_irq_disable_i <= 1'h0;
		edge_clr_i <= 12'hfff;
		@(posedge sys_clk_i);
		edge_clr_i <= 12'h000;
		$display("edge test done");
	endtask
	task automatic t_level();
		cfg(8'h40, 8'h00);
		level_en_i <= 2'h1;
		p4_in_i <= 8'h45;
		cyc(16);
		`CHK({second_flag_o, irq_o}, 3'h3)
		cpu_irq_disable_i <= 1'h1;
		p4_in_i <= 8'h46;
		n = 0;
		repeat (8) begin
			@(posedge sys_clk_i);
			n += nmi_o;
		end
		`CHK(n, 1)
		`CHK(second_flag_o, 2'h0)
		cpu_irq_disable_i <= 1'h0;
		$display("level test done");
	endtask
	task automatic t_uart_tmr();
		async_ctrl_i <= 8'h21;
		p6_in_i <= 2'h2;
		run <= 1'h1;
		cyc(12);
		`CHK({p6_o.oe[1], p6_o.out[1], uart_rx_o}, 3'h4)
		n = 0;
		repeat (64) begin
			@(posedge sys_clk_i);
			n += timer_a_count_o;
		end
		`CHK(n, 8)
		uart_uses_timer_i <= 1'h1;
		async_ctrl_i <= 8'h00;
		cyc(4);
		`CHK({p6_o.oe[1], uart_rx_o}, 2'h1)
		n = 0;
		repeat (16) begin
			@(posedge sys_clk_i);
			n += timer_a_count_o;
		end
		`CHK(n, 0)
		w = timer_a_wave_out_o;
		timer_a_timeout_i <= 1'h1;
		@(posedge sys_clk_i);
		timer_a_timeout_i <= 1'h0;
		cyc(2);
		`CHK(timer_a_wave_out_o, ~w)
		$display("uart timer test done");
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Main sequence; two resets first, one for each strap level
	initial begin
		rst(1'h0, 8'h89);
		rst(1'h1, 8'h00);
		t_bus();
		t_cs();
		t_edge();
		t_level();
		t_uart_tmr();
		conclude();
	end
endmodule
